// ==== logic/supm_pkg.sv ====
package supm_pkg;
	// Clock rate and documented times
	localparam int CLK_KHZ       = 100_000;
	localparam int MTC_GAP_MS    = 200;
	localparam int HOLD_DLY_MS   = 500;
	localparam int REPEAT_MS     = 50;
	localparam int MTC_GAP_CYC   = MTC_GAP_MS * CLK_KHZ;
	localparam int HOLD_DLY_CYC  = HOLD_DLY_MS * CLK_KHZ;
	localparam int REPEAT_CYC    = REPEAT_MS * CLK_KHZ;

	// Parameter menu indices, in scroll order
	localparam int NP            = 19;
	localparam logic [4:0] P_GEN_START = 5'h00;
	localparam logic [4:0] P_DIG_REF   = 5'h01;
	localparam logic [4:0] P_RATE      = 5'h02;
	localparam logic [4:0] P_PULL1     = 5'h03;
	localparam logic [4:0] P_PULL4     = 5'h04;
	localparam logic [4:0] P_WCLK_MUL  = 5'h05;
	localparam logic [4:0] P_VERTICAL_INTERVAL_CODE_INS  = 5'h06;
	localparam logic [4:0] P_READ_LINE = 5'h07;
	localparam logic [4:0] P_GEN_LINE  = 5'h08;
	localparam logic [4:0] P_BURN      = 5'h09;
	localparam logic [4:0] P_COAST     = 5'h0A;
	localparam logic [4:0] P_LTC_LVL   = 5'h0B;
	localparam logic [4:0] P_SERVO     = 5'h0C;
	localparam logic [4:0] P_HOLD      = 5'h0D;
	localparam logic [4:0] P_PPF       = 5'h0E;
	localparam logic [4:0] P_TACH_DIR  = 5'h0F;
	localparam logic [4:0] P_VIDEO     = 5'h10;
	localparam logic [4:0] P_IDLE_MTC  = 5'h11;
	localparam logic [4:0] P_LEGACY    = 5'h12;
	localparam logic [4:0] A_STATUS    = 5'h1F;

	// Value ranges and reset values, index 18 first
	localparam logic [NP-1:0][15:0] P_DEF = {
		16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0002,
		16'h0000, 16'h0002, 16'h001B, 16'h0008, 16'h0001,
		16'h000E, 16'h0000, 16'h0001, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0000};
	localparam logic [NP-1:0][15:0] P_MAX = {
		16'h0001, 16'h0001, 16'h0001, 16'h0003, 16'h03E7,
		16'h0001, 16'h0003, 16'h0021, 16'h00FF, 16'h0001,
		16'h0014, 16'h0014, 16'h0001, 16'h0001, 16'h0002,
		16'h0002, 16'h0005, 16'h0001, 16'hFFFF};
	localparam logic [NP-1:0][15:0] P_MIN = {
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001,
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h000A, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0000};

	// Display offsets for signed readouts
	localparam logic [15:0] LTC_DBU_OFS = 16'h0018;
	localparam logic [15:0] SERVO_OFS   = 16'h0003;
	// Pull offsets in units of 0.001 percent
	localparam logic [15:0] PULL_SMALL  = 16'h0064;
	localparam logic [15:0] PULL_UP4    = 16'h1047;
	localparam logic [15:0] PULL_DN4    = 16'h0FA0;

	// Display modes
	localparam logic [1:0] D_TIME  = 2'h0;
	localparam logic [1:0] D_NAME  = 2'h1;
	localparam logic [1:0] D_VALUE = 2'h2;

	typedef enum logic [1:0] {
		ST_BOOT,
		ST_IDLE,
		ST_BROWSE,
		ST_EDIT
	} supm_state_e;

	typedef struct packed {
		supm_state_e          st;
		logic [4:0]           idx;
		logic [15:0]          edit;
		logic [NP-1:0][15:0]  val;
		logic [2:0]           b1;
		logic [2:0]           b2;
		logic [2:0]           b3;
		logic [5:0]           l1;
		logic [5:0]           l2;
		logic                 frm_d;
		logic                 code_d;
		logic [31:0]          hold_cnt;
		logic [31:0]          mtc_cnt;
		logic                 mtc_p;
		logic [15:0]          fw_cnt;
		logic [1:0]           ph;
		logic                 nv_rd;
		logic                 nv_wr;
		logic [4:0]           nv_addr;
		logic [15:0]          nv_wdata;
		logic [15:0]          rdata;
		logic                 vertical_interval_code_ins;
	} supm_state_s;
endpackage : supm_pkg

// ==== logic/supm_menu.sv ====
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/100ps
module supm_menu #(
	parameter int MTC_GAP  = supm_pkg::MTC_GAP_CYC,
	parameter int HOLD_DLY = supm_pkg::HOLD_DLY_CYC,
	parameter int REPEAT   = supm_pkg::REPEAT_CYC
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rstn,
	input  wire logic        i_set_sw,
	input  wire logic        i_up_sw,
	input  wire logic        i_down_sw,
	input  wire logic        i_video_present,
	input  wire logic        i_insert_mode_ok,
	input  wire logic        i_ref_present,
	input  wire logic        i_code_valid,
	input  wire logic        i_ltc_running,
	input  wire logic        i_frame_tick,
	input  wire logic        i_large_pull_avail,
	input  wire logic        i_nv_ok,
	input  wire logic [15:0] i_nv_rdata,
	input  wire logic [4:0]  i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic [15:0]      o_rdata,
	output logic             o_nv_rd,
	output logic             o_nv_wr,
	output logic [4:0]       o_nv_addr,
	output logic [15:0]      o_nv_wdata,
	output logic [1:0]       o_disp_mode,
	output logic [4:0]       o_disp_param,
	output logic [15:0]      o_disp_value,
	output logic             o_digital_clock_ref_select,
	output logic [2:0]       o_sample_rate_select,
	output logic [15:0]      o_rate_offset,
	output logic             o_word_clock_out_multiplier,
	output logic             o_base_rate_48k,
	output logic             o_vertical_code_insert,
	output logic             o_read_line_auto,
	output logic [4:0]       o_read_line,
	output logic [4:0]       o_vertical_code_write_lines,
	output logic             o_overlay_enable,
	output logic             o_regen_active,
	output logic [5:0]       o_linear_code_out_level,
	output logic [1:0]       o_servo_gain_offset,
	output logic             o_rate_hold,
	output logic [9:0]       o_tach_pulses_per_frame,
	output logic [1:0]       o_tach_direction_config,
	output logic             o_video_pal,
	output logic             o_mtc_burst,
	output logic             o_legacy_emulation_enable
);
	import supm_pkg::*;

	supm_state_s s_r;
	supm_state_s s_nxt;

	logic [2:0]  press;
	logic [2:0]  held;
	logic        set_p;
	logic        up_p;
	logic        dn_p;
	logic        rep_p;
	logic [15:0] cur;
	logic        code_s;
	logic        frm_s;

	// Second sync stage only; first stage feeds nothing else
	assign held   = s_r.b2;
	assign press  = s_r.b2 & ~s_r.b3;
	assign set_p  = press[2];
	assign code_s = s_r.l2[2];
	assign frm_s  = s_r.l2[0];
	assign cur    = s_r.val[s_r.idx];

	// Auto-repeat only on the pulses-per-frame edit
	assign rep_p = (s_r.st == ST_EDIT) && (s_r.idx == P_PPF) &&
		(held[1] ^ held[0]) && (s_r.hold_cnt >= 32'(HOLD_DLY)) &&
		((s_r.hold_cnt - 32'(HOLD_DLY)) % 32'(REPEAT) == 32'h0);
	assign up_p = press[1] | (rep_p & held[1]);
	assign dn_p = press[0] | (rep_p & held[0]);

	// One step with wrap between the value limits
	function automatic logic [15:0] step(input logic [4:0]  p,
	                                     input logic [15:0] v,
	                                     input logic        up);
		logic [15:0] r;
		r = v;
		if (up) begin
			r = (v >= P_MAX[p]) ? P_MIN[p] : 16'(v + 16'h1);
		end else begin
			r = (v <= P_MIN[p]) ? P_MAX[p] : 16'(v - 16'h1);
		end
		return r;
	endfunction : step

	// Next-state logic for menu, settings, store and timers
	always_comb begin
		s_nxt       = s_r;
		s_nxt.b1    = {i_set_sw, i_up_sw, i_down_sw};
		s_nxt.b2    = s_r.b1;
		s_nxt.b3    = s_r.b2;
		s_nxt.l1    = {i_video_present, i_insert_mode_ok, i_ref_present,
			i_code_valid, i_ltc_running, i_frame_tick};
		s_nxt.l2    = s_r.l1;
		s_nxt.frm_d = frm_s;
		s_nxt.code_d = code_s;
		s_nxt.nv_wr = 1'b0;
		s_nxt.nv_rd = 1'b0;
		s_nxt.rdata = 16'h0000;
		s_nxt.mtc_p = 1'b0;

		// Held-switch timer for repeat
		if (held[1] ^ held[0]) begin
			s_nxt.hold_cnt = 32'(s_r.hold_cnt + 32'h1);
		end else begin
			s_nxt.hold_cnt = 32'h0;
		end

		unique case (s_r.st)
			// Settings reload from the store, one word per three cycles
			ST_BOOT: begin
				s_nxt.ph = 2'(s_r.ph + 2'h1);
				if (s_r.ph == 2'h0) begin
					s_nxt.nv_rd   = 1'b1;
					s_nxt.nv_addr = s_r.idx;
				end else if (s_r.ph == 2'h2) begin
					s_nxt.ph = 2'h0;
					if (i_nv_ok) begin
						s_nxt.val[s_r.idx] = i_nv_rdata;
					end
					if (s_r.idx == 5'(NP - 1)) begin
						s_nxt.st  = ST_IDLE;
						s_nxt.idx = 5'h0;
					end else begin
						s_nxt.idx = 5'(s_r.idx + 5'h1);
					end
				end
			end
			ST_IDLE: begin
				if (set_p) begin
					s_nxt.st = ST_BROWSE;
				end
			end
			// Scroll the list one entry per press
			ST_BROWSE: begin
				if (set_p) begin
					s_nxt.st   = ST_EDIT;
					s_nxt.edit = cur;
				end else if (up_p) begin
					s_nxt.idx = (s_r.idx == 5'(NP - 1)) ? 5'h0 :
						5'(s_r.idx + 5'h1);
				end else if (dn_p) begin
					s_nxt.idx = (s_r.idx == 5'h0) ? 5'(NP - 1) :
						5'(s_r.idx - 5'h1);
				end
			end
			// Edit a shadow copy; live value untouched until set
			ST_EDIT: begin
				if (set_p) begin
					s_nxt.st             = ST_IDLE;
					s_nxt.val[s_r.idx]   = s_r.edit;
					s_nxt.nv_wr          = 1'b1;
					s_nxt.nv_addr        = s_r.idx;
					s_nxt.nv_wdata       = s_r.edit;
				end else if (up_p) begin
					s_nxt.edit = step(s_r.idx, s_r.edit, 1'b1);
				end else if (dn_p) begin
					s_nxt.edit = step(s_r.idx, s_r.edit, 1'b0);
				end
			end
		endcase

		// Host writes commit directly; panel commit wins a collision
		if (i_wr && (i_addr < 5'(NP)) && (s_r.st != ST_BOOT) &&
			!(s_r.st == ST_EDIT && set_p)) begin
			s_nxt.val[i_addr] = i_wdata;
			s_nxt.nv_wr       = 1'b1;
			s_nxt.nv_addr     = i_addr;
			s_nxt.nv_wdata    = i_wdata;
		end

		// Read data, one cycle after the strobe; unmapped reads zero
		if (i_rd) begin
			if (i_addr < 5'(NP)) begin
				s_nxt.rdata = s_r.val[i_addr];
			end else if (i_addr == A_STATUS) begin
				s_nxt.rdata = {12'h000, o_regen_active, s_r.vertical_interval_code_ins,
					s_r.st};
			end
		end

		// Coast counter reloads while code is valid
		if (code_s) begin
			s_nxt.fw_cnt = s_r.val[P_COAST];
		end else if (frm_s && !s_r.frm_d && s_r.fw_cnt != 16'h0) begin
			s_nxt.fw_cnt = 16'(s_r.fw_cnt - 16'h1);
		end

		// Idle burst timer, restarts whenever bursts are not wanted
		if (!s_r.l2[1] && s_r.val[P_IDLE_MTC] != 16'h0) begin
			if (s_r.mtc_cnt >= 32'(MTC_GAP - 1)) begin
				s_nxt.mtc_cnt = 32'h0;
				s_nxt.mtc_p   = 1'b1;
			end else begin
				s_nxt.mtc_cnt = 32'(s_r.mtc_cnt + 32'h1);
			end
		end else begin
			s_nxt.mtc_cnt = 32'h0;
		end

		// Insertion needs all three conditions
		s_nxt.vertical_interval_code_ins = (s_r.val[P_VERTICAL_INTERVAL_CODE_INS] != 16'h0) &&
			s_r.l2[5] && s_r.l2[4];
	end

	// State register
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			s_r     <= '0;
			s_r.st  <= ST_BOOT;
			s_r.val <= P_DEF;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Display: abbreviation code while browsing, value while editing
	always_comb begin
		o_disp_mode  = D_TIME;
		o_disp_param = s_r.idx;
		o_disp_value = s_r.edit;
		if (s_r.st == ST_BROWSE) begin
			o_disp_mode = D_NAME;
		end else if (s_r.st == ST_EDIT) begin
			o_disp_mode = D_VALUE;
			if (s_r.idx == P_LTC_LVL) begin
				o_disp_value = 16'(s_r.edit - LTC_DBU_OFS);
			end else if (s_r.idx == P_SERVO) begin
				o_disp_value = 16'(s_r.edit - SERVO_OFS);
			end
		end
	end

	// Pull offset; large pull counts only when available
	always_comb begin
		o_rate_offset = 16'h0000;
		if (s_r.val[P_PULL1] == 16'h1) begin
			o_rate_offset = PULL_SMALL;
		end else if (s_r.val[P_PULL1] == 16'h2) begin
			o_rate_offset = 16'(16'h0 - PULL_SMALL);
		end
		if (i_large_pull_avail && s_r.val[P_PULL4] == 16'h1) begin
			o_rate_offset = 16'(o_rate_offset + PULL_UP4);
		end else if (i_large_pull_avail && s_r.val[P_PULL4] == 16'h2) begin
			o_rate_offset = 16'(o_rate_offset - PULL_DN4);
		end
	end

	// Committed settings drive the downstream logic
	assign o_rdata      = s_r.rdata;
	assign o_nv_rd      = s_r.nv_rd;
	assign o_nv_wr      = s_r.nv_wr;
	assign o_nv_addr    = s_r.nv_addr;
	assign o_nv_wdata   = s_r.nv_wdata;
	assign o_digital_clock_ref_select = s_r.val[P_DIG_REF][0];
	assign o_sample_rate_select = s_r.val[P_RATE][2:0];
	assign o_word_clock_out_multiplier = s_r.val[P_WCLK_MUL][0];
	// Odd rate codes are the 48k family
	assign o_base_rate_48k = s_r.val[P_RATE][0];
	assign o_vertical_code_insert = s_r.vertical_interval_code_ins;
	assign o_read_line_auto = (s_r.val[P_READ_LINE] == 16'h0);
	assign o_read_line  = s_r.val[P_READ_LINE][4:0];
	assign o_vertical_code_write_lines = s_r.val[P_GEN_LINE][4:0];
	// Overlay size, place and colour are not held here
	assign o_overlay_enable = s_r.val[P_BURN][0];
	assign o_regen_active = code_s | (s_r.fw_cnt != 16'h0);
	assign o_linear_code_out_level = s_r.val[P_LTC_LVL][5:0];
	assign o_servo_gain_offset = s_r.val[P_SERVO][1:0];
	assign o_rate_hold = s_r.val[P_HOLD][0] & ~s_r.l2[3];
	assign o_tach_pulses_per_frame = s_r.val[P_PPF][9:0];
	assign o_tach_direction_config = s_r.val[P_TACH_DIR][1:0];
	assign o_video_pal  = s_r.val[P_VIDEO][0];
	assign o_mtc_burst  = s_r.mtc_p;
	assign o_legacy_emulation_enable = s_r.val[P_LEGACY][0];

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);

	// Checks on menu, store and output paths; reset disables them all
	a_browse_step_up: assert property (
		(s_r.st == ST_BROWSE && !set_p && press[1] &&
		s_r.idx < 5'(NP - 1)) |=> s_r.idx == $past(s_r.idx) + 5'h1)
		else $error("browse did not step up");

	a_edit_loads_value: assert property (
		(s_r.st == ST_BROWSE && set_p) |=>
		(s_r.st == ST_EDIT && s_r.edit == s_r.val[s_r.idx]))
		else $error("edit did not load value");

	a_edit_no_effect: assert property (
		(s_r.st == ST_EDIT && !set_p && !i_wr) |=> $stable(s_r.val))
		else $error("setting changed before set");

	a_commit_store: assert property (
		(s_r.st == ST_EDIT && set_p) |=> (o_nv_wr &&
		o_nv_wdata == $past(s_r.edit) && o_nv_addr == $past(s_r.idx)))
		else $error("commit not written to store");

	a_insert_gate: assert property (
		o_vertical_code_insert |-> ($past(s_r.l2[5]) &&
		$past(s_r.l2[4]) &&
		$past(s_r.val[P_VERTICAL_INTERVAL_CODE_INS]) != 16'h0))
		else $error("insert without all conditions");

	a_edit_in_range: assert property (
		(s_r.st == ST_EDIT && !set_p && (up_p || dn_p)) |=>
		(s_r.edit >= P_MIN[s_r.idx] && s_r.edit <= P_MAX[s_r.idx]))
		else $error("edit value left its range");

	a_burst_source: assert property (
		o_mtc_burst |-> (!$past(s_r.l2[1]) &&
		$past(s_r.val[P_IDLE_MTC]) != 16'h0))
		else $error("burst while not idle or muted");

	a_read_idle: assert property (
		!$past(i_rd) |-> o_rdata == 16'h0000)
		else $error("read data outside read cycle");

	a_coast_hold: assert property (
		($fell(code_s) && s_r.val[P_COAST] != 16'h0) |->
		o_regen_active [*2])
		else $error("regeneration dropped at loss");

	a_burst_gap: assert property (
		o_mtc_burst |=> !o_mtc_burst [*8])
		else $error("bursts too close");

	a_level_range: assert property (
		(s_r.st != ST_BOOT && $rose(o_nv_wr) &&
		o_nv_addr == P_LTC_LVL && !$past(i_wr)) |->
		o_nv_wdata <= P_MAX[P_LTC_LVL])
		else $error("level out of range");

	a_base_family: assert property (
		$changed(s_r.val[P_RATE]) |=>
		o_base_rate_48k == (o_sample_rate_select inside {3'h1, 3'h3, 3'h5}))
		else $error("base rate family wrong");
endmodule : supm_menu

// ==== dv/supm_nv_model.sv ====
`timescale 1ns/100ps
// Nonvolatile store behind the menu; its content outlives any reset
module supm_nv_model
	import supm_pkg::*;
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_nv_rd,
	input  wire logic        i_nv_wr,
	input  wire logic [4:0]  i_nv_addr,
	input  wire logic [15:0] i_nv_wdata,
	output logic [15:0]      o_nv_rdata
);
	logic [15:0] mem [NP];
	logic        rd_d;

	// Factory content; never cleared so committed values survive power-off
	initial begin
		for (int i = 0; i < NP; i++) begin
			mem[i] = P_DEF[i];
		end
		o_nv_rdata = 16'h0000;
		rd_d = 1'b0;
	end

	// Answer stands two cycles, then the bus shows junk, not a stale copy
	always @(posedge i_ref_clk) begin
		rd_d <= i_nv_rd;
		if (i_nv_wr) begin
			mem[i_nv_addr] <= i_nv_wdata;
		end
		if (i_nv_rd) begin
			o_nv_rdata <= mem[i_nv_addr];
		end else if (!rd_d) begin
			o_nv_rdata <= ~o_nv_rdata;
		end
	end
endmodule : supm_nv_model

// ==== dv/supm_menu_test.sv ====
`timescale 1ns/100ps
module supm_menu_test;
	import supm_pkg::*;
	localparam int GAP = 50;
	logic        clk = 1'b0, rstn = 1'b0;
	logic [2:0]  sw = 3'h0;
	logic        video = 1'b0, mode_ok = 1'b0, ref_ok = 1'b1;
	logic        code_ok = 1'b0, ltc_run = 1'b0, frame = 1'b0;
	logic        large_ok = 1'b0, nv_ok = 1'b0, wr = 1'b0, rd = 1'b0;
	logic [4:0]  addr = 5'h00, nv_addr, rline, wline, dparam;
	logic [15:0] wdata = 16'h0000, rdata, nv_wdata, nv_rdata, dval, rofs;
	logic        nv_rd, nv_wr, dref, wmul, b48, vins, rauto, burn, regen;
	logic        hold, pal, mtc, legacy;
	logic [1:0]  dmode, servo, tdir;
	logic [2:0]  rsel;
	logic [5:0]  lvl;
	logic [9:0]  ppf;
	int          n_errors = 0, comparisons = 0, n;

	always #5 clk = ~clk;

	supm_nv_model nv (.i_ref_clk(clk), .i_nv_rd(nv_rd), .i_nv_wr(nv_wr),
		.i_nv_addr(nv_addr), .i_nv_wdata(nv_wdata), .o_nv_rdata(nv_rdata));

	// Short counts keep burst and auto-repeat scenarios brief
	supm_menu #(.MTC_GAP(GAP), .HOLD_DLY(20), .REPEAT(4)) dut (
		.i_ref_clk(clk), .i_rstn(rstn), .i_set_sw(sw[0]), .i_up_sw(sw[1]),
		.i_down_sw(sw[2]), .i_video_present(video),
		.i_insert_mode_ok(mode_ok), .i_ref_present(ref_ok),
		.i_code_valid(code_ok), .i_ltc_running(ltc_run),
		.i_frame_tick(frame), .i_large_pull_avail(large_ok),
		.i_nv_ok(nv_ok), .i_nv_rdata(nv_rdata), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.o_nv_rd(nv_rd), .o_nv_wr(nv_wr), .o_nv_addr(nv_addr),
		.o_nv_wdata(nv_wdata), .o_disp_mode(dmode), .o_disp_param(dparam),
		.o_disp_value(dval), .o_digital_clock_ref_select(dref),
		.o_sample_rate_select(rsel), .o_rate_offset(rofs),
		.o_word_clock_out_multiplier(wmul), .o_base_rate_48k(b48),
		.o_vertical_code_insert(vins), .o_read_line_auto(rauto),
		.o_read_line(rline), .o_vertical_code_write_lines(wline),
		.o_overlay_enable(burn), .o_regen_active(regen),
		.o_linear_code_out_level(lvl), .o_servo_gain_offset(servo),
		.o_rate_hold(hold), .o_tach_pulses_per_frame(ppf),
		.o_tach_direction_config(tdir), .o_video_pal(pal),
		.o_mtc_burst(mtc), .o_legacy_emulation_enable(legacy));

	task automatic report_and_stop;
		if (n_errors == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : report_and_stop

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : cyc

	task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		cyc(2);
	endtask : wr_reg

	// Read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		check(rdata, exp);
	endtask : rd_chk

	// Operator press: bit 0 set, bit 1 up, bit 2 down; switches are async
	task automatic press(input logic [2:0] m, input int len);
		@(posedge clk);
		sw <= m;
		repeat (len) @(posedge clk);
		sw <= 3'h0;
		cyc(6);
	endtask : press

	task automatic count_mtc;
		n = 0;
		repeat (3 * GAP) begin
			cyc(1);
			n += int'(mtc === 1'b1);
		end
	endtask : count_mtc

	task automatic tick_frame;
		@(posedge clk);
		frame <= 1'b1;
		cyc(3);
		@(posedge clk);
		frame <= 1'b0;
		cyc(3);
	endtask : tick_frame

	// Hang guard: the whole sequence needs well under this span
	initial begin
		#400us;
		n_errors++;
		report_and_stop();
	end

	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		rd_chk(A_STATUS, 16'h0000);
		cyc(70);
		rd_chk(P_GEN_LINE, 16'h000E);
		check(16'(wline), 16'h000E);
		check(16'(lvl), 16'h001B);
		check(16'(rauto), 16'h0001);
		rd_chk(A_STATUS, 16'h0001);
		// Browse with wrap, then edit servo gain
		press(3'h1, 2);
		check(16'(dmode), 16'(D_NAME));
		check(16'(dparam), 16'(P_GEN_START));
		press(3'h2, 2);
		check(16'(dparam), 16'(P_DIG_REF));
		press(3'h4, 2);
		press(3'h4, 2);
		check(16'(dparam), 16'(P_LEGACY));
		repeat (13) press(3'h2, 2);
		check(16'(dparam), 16'(P_SERVO));
		press(3'h1, 2);
		check(16'(dmode), 16'(D_VALUE));
		check(dval, 16'hFFFF);
		press(3'h2, 2);
		check(dval, 16'h0000);
		check(16'(servo), 16'h0002);
		press(3'h1, 2);
		check(16'(servo), 16'h0003);
		check(nv.mem[12], 16'h0003);
		check(16'(dmode), 16'(D_TIME));
		// Pulses per frame: single step, then held switch repeats
		press(3'h1, 2);
		repeat (2) press(3'h2, 2);
		press(3'h1, 2);
		check(dval, 16'h0002);
		press(3'h2, 2);
		check(dval, 16'h0003);
		press(3'h2, 60);
		check(16'(dval > 16'h0008), 16'h0001);
		press(3'h1, 2);
		check(16'(ppf), 16'h000E);
		// Level edit shows dBu and wraps from +9 to -24
		press(3'h1, 2);
		repeat (3) press(3'h4, 2);
		press(3'h1, 2);
		check(dval, 16'h0003);
		repeat (6) press(3'h2, 2);
		check(dval, 16'h0009);
		press(3'h2, 2);
		check(dval, 16'hFFE8);
		press(3'h1, 2);
		check(16'(lvl), 16'h0000);
		// Settings written over the register port
		wr_reg(P_WCLK_MUL, 16'h0001);
		check(16'(wmul), 16'h0001);
		wr_reg(P_DIG_REF, 16'h0001);
		check(16'(dref), 16'h0001);
		for (int r = 0; r < 6; r++) begin
			wr_reg(P_RATE, 16'(r));
			check(16'(b48), 16'(r[0]));
			check(16'(rsel), 16'(r));
		end
		wr_reg(P_PULL1, 16'h0001);
		check(rofs, 16'h0064);
		wr_reg(P_PULL1, 16'h0002);
		check(rofs, 16'hFF9C);
		wr_reg(P_PULL1, 16'h0000);
		wr_reg(P_PULL4, 16'h0001);
		check(rofs, 16'h0000);
		@(posedge clk);
		large_ok <= 1'b1;
		cyc(2);
		check(rofs, 16'h1047);
		wr_reg(P_PULL4, 16'h0002);
		check(rofs, 16'hF060);
		wr_reg(5'h13, 16'h0001);
		rd_chk(5'h13, 16'h0000);
		wr_reg(P_BURN, 16'h0000);
		check(16'(burn), 16'h0000);
		wr_reg(P_TACH_DIR, 16'h0002);
		check(16'(tdir), 16'h0002);
		wr_reg(P_VIDEO, 16'h0001);
		check(16'(pal), 16'h0001);
		wr_reg(P_LEGACY, 16'h0001);
		check(16'(legacy), 16'h0001);
		wr_reg(P_READ_LINE, 16'h0005);
		check({11'h000, rline}, 16'h0005);
		check(16'(rauto), 16'h0000);
		// Insertion needs enable, video and a permitting mode
		for (int i = 0; i < 8; i++) begin
			wr_reg(P_VERTICAL_INTERVAL_CODE_INS, 16'(i[2]));
			@(posedge clk);
			video <= i[1];
			mode_ok <= i[0];
			cyc(6);
			check(16'(vins), 16'(i == 7));
		end
		wr_reg(P_HOLD, 16'h0001);
		@(posedge clk);
		ref_ok <= 1'b0;
		cyc(6);
		check(16'(hold), 16'h0001);
		@(posedge clk);
		ref_ok <= 1'b1;
		cyc(6);
		check(16'(hold), 16'h0000);
		// Coast through eight frames after code loss
		@(posedge clk);
		code_ok <= 1'b1;
		cyc(6);
		check(16'(regen), 16'h0001);
		@(posedge clk);
		code_ok <= 1'b0;
		repeat (7) tick_frame();
		check(16'(regen), 16'h0001);
		repeat (2) tick_frame();
		check(16'(regen), 16'h0000);
		// Idle bursts: exactly three per three gaps, none otherwise
		count_mtc();
		check(16'(n), 16'h0003);
		@(posedge clk);
		ltc_run <= 1'b1;
		cyc(4);
		count_mtc();
		check(16'(n), 16'h0000);
		@(posedge clk);
		ltc_run <= 1'b0;
		wr_reg(P_IDLE_MTC, 16'h0000);
		count_mtc();
		check(16'(n), 16'h0000);
		// Power cycle with a good store restores committed values
		@(posedge clk);
		nv_ok <= 1'b1;
		rstn <= 1'b0;
		cyc(3);
		@(posedge clk);
		rstn <= 1'b1;
		cyc(70);
		check(16'(servo), 16'h0003);
		check(16'(pal), 16'h0001);
		check(16'(lvl), 16'h0000);
		check(16'(ppf), 16'h000E);
		check(16'(legacy), 16'h0001);
		report_and_stop();
	end
endmodule : supm_menu_test
